// File: include/slfc_map.svh
// Purpose: Offsets, field positions, reset values and counts for the
//          split lock and fetch control block
// Assumes: APB byte address is four times the register index
// Notes:   Definitions only
`ifndef SLFC_MAP_SVH
`define SLFC_MAP_SVH

// ****************************************************************
// Register indices (byte address = index * 4)
// ****************************************************************
`define SLFC_CTRL_IDX        8'h33
`define SLFC_STAT_IDX        8'h34

// ****************************************************************
// Control register fields
// ****************************************************************
`define SLFC_SPLIT_DIS_BIT   31
`define SLFC_ISB_DIS_BIT     30
`define SLFC_CTRL_RST        32'h00000000

// ****************************************************************
// Status register fields
// ****************************************************************
`define SLFC_ST_LOCK_BIT     0
`define SLFC_ST_SEQ_BIT      1
`define SLFC_ST_FEAT_BIT     2
`define SLFC_ST_READY_BIT    3
`define SLFC_ST_DROP_BIT     4
`define SLFC_ST_CNT_LSB      16
`define SLFC_ST_CNT_MSB      31

// ****************************************************************
// Timing
// ****************************************************************
`define SLFC_STRAP_WAIT      2'h3

`endif

// File: include/slfc_pkg.sv
// Purpose: Types shared by the split lock and fetch control files
// Assumes: Nothing
// Notes:   Constants live in slfc_map.svh
package slfc_pkg;

    // ****************************************************************
    // Lock sequencer states
    // ****************************************************************
    typedef enum logic [1:0] {
        LK_IDLE,
        LK_HELD,
        LK_BYPASS
    } slfc_lock_state_t;

endpackage : slfc_pkg

// File: hw/slfc_lock_gen.sv
// Purpose: Drives the bus lock for one locked read-modify-write sequence
// Assumes: seq_act is high for the whole sequence, same clock domain
// Notes:   Split and disable are sampled once, at sequence start
module slfc_lock_gen (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic seq_act,
    input  wire logic line_split,
    input  wire logic split_dis,
    output logic      lock_n,
    output logic      bypass_pulse,
    output logic      seq_busy
);

    slfc_pkg::slfc_lock_state_t state_r;
    slfc_pkg::slfc_lock_state_t state_nxt;

    // ****************************************************************
    // Sequence decision
    // ****************************************************************
    // Decision is frozen for the whole sequence; a mid-sequence
    // write to the disable bit must not drop the lock half way
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            slfc_pkg::LK_IDLE: begin
                if (seq_act) begin
                    if (line_split && split_dis) begin
                        state_nxt = slfc_pkg::LK_BYPASS;
                    end else begin
                        state_nxt = slfc_pkg::LK_HELD;
                    end
                end
            end
            slfc_pkg::LK_HELD: begin
                if (!seq_act) begin
                    state_nxt = slfc_pkg::LK_IDLE;
                end
            end
            slfc_pkg::LK_BYPASS: begin
                if (!seq_act) begin
                    state_nxt = slfc_pkg::LK_IDLE;
                end
            end
            default: begin
                state_nxt = slfc_pkg::LK_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= slfc_pkg::LK_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Registered lock, low for every cycle the sequence is held
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_n <= 1'b1;
        end else begin
            lock_n <= (state_nxt != slfc_pkg::LK_HELD);
        end
    end

    // One pulse per sequence that runs without the lock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bypass_pulse <= 1'b0;
        end else begin
            bypass_pulse <= (state_r == slfc_pkg::LK_IDLE) &&
                            (state_nxt == slfc_pkg::LK_BYPASS);
        end
    end

    assign seq_busy = (state_r != slfc_pkg::LK_IDLE);

endmodule // slfc_lock_gen

// File: hw/slfc_top.sv
// Purpose: Lock and prefetch control register with its bus lock logic
// Assumes: APB master on SYS_CLK; core lock inputs on SYS_CLK;
//          feature strap is an asynchronous pin
// Notes:   Zero wait-state APB slave, registered read data
//
// Function
// - Set bit 31: split locks skip bus lock
// - Split-lock disable bit resets to zero
// - Bit clear: misaligned locks hold lock throughout
// - Bit set: split sequence carries no atomicity
// - Single-line locked sequences always assert lock
// - Writing one to bit 30 disables streaming
// - Streaming disable bit resets to zero
// - Older revisions: bit 31 reserved, no effect
// - Older revisions drop bit 30 writes; a written one sets the status drop flag
`include "slfc_map.svh"

module slfc_top #(
    parameter int AW = 12
) (
    input  wire logic          SYS_CLK,
    input  wire logic          RST_N,
    // APB slave
    input  wire logic          PSEL,
    input  wire logic          PENABLE,
    input  wire logic          PWRITE,
    input  wire logic [AW-1:0] PADDR,
    input  wire logic [31:0]   PWDATA,
    input  wire logic [3:0]    PSTRB,
    output logic [31:0]        PRDATA,
    output logic               PREADY,
    output logic               PSLVERR,
    // Revision strap, high on silicon with the new control bits
    input  wire logic          FEATURE_REV_PIN,
    // Core side locked sequence
    input  wire logic          CORE_LOCK_SEQ,
    input  wire logic          CORE_LINE_SPLIT,
    // System bus and fetch unit
    output logic               BUS_LOCK_N,
    output logic               ISB_ENABLE
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic        strap_s1_r;
    logic        strap_s2_r;
    logic [1:0]  strap_wait_r;
    logic        feat_r;
    logic        feat_ready_r;
    logic        split_dis_r;
    logic        isb_dis_r;
    logic        drop_r;
    logic [15:0] byp_cnt_r;
    logic [31:0] ctrl_view;
    logic [31:0] stat_view;
    logic [31:0] rd_mux;
    logic        setup_ph;
    logic        access_ph;
    logic        wr_ctrl;
    logic        wr_stat;
    logic        hit;
    logic        byp_pulse;
    logic        seq_busy;
    logic        lock_n;
    logic        drop_evt;

    // Reset word as a named constant so single bits can be selected
    localparam logic [31:0] CTRL_RST = `SLFC_CTRL_RST;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    // Exact byte address match, low two bits zero, for a register index; used for read and write
    function automatic logic reg_sel(input logic [AW-1:0] addr,
                                     input logic [7:0]    idx);
        logic [AW-1:0] byte_addr;
        byte_addr = AW'({idx, 2'b00});
        reg_sel = (addr == byte_addr);
    endfunction

    assign setup_ph  = PSEL && !PENABLE;
    assign access_ph = PSEL && PENABLE;
    assign hit       = reg_sel(PADDR, `SLFC_CTRL_IDX) ||
                       reg_sel(PADDR, `SLFC_STAT_IDX);
    assign wr_ctrl   = access_ph && PWRITE &&
                       reg_sel(PADDR, `SLFC_CTRL_IDX);
    assign wr_stat   = access_ph && PWRITE &&
                       reg_sel(PADDR, `SLFC_STAT_IDX);

    // ****************************************************************
    // Revision strap
    // ****************************************************************
    // Two-stage synchroniser; only the second stage is read
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            strap_s1_r <= 1'b0;
            strap_s2_r <= 1'b0;
        end else begin
            strap_s1_r <= FEATURE_REV_PIN;
            strap_s2_r <= strap_s1_r;
        end
    end

    // Strap caught once the synchroniser has flushed after release;
    // until then the new bits behave as on older silicon
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            strap_wait_r <= 2'h0;
            feat_r       <= 1'b0;
            feat_ready_r <= 1'b0;
        end else if (!feat_ready_r) begin
            strap_wait_r <= strap_wait_r + 2'h1;
            if (strap_wait_r == `SLFC_STRAP_WAIT) begin
                feat_r       <= strap_s2_r;
                feat_ready_r <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Control register
    // ****************************************************************
    // Split-lock disable; on older revisions the bit is reserved,
    // so the write is dropped and the bit stays at zero
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            split_dis_r <= CTRL_RST[`SLFC_SPLIT_DIS_BIT];
        end else if (wr_ctrl && PSTRB[3] && feat_r) begin
            split_dis_r <= PWDATA[`SLFC_SPLIT_DIS_BIT];
        end
    end

    // Streaming buffer disable, ignored on older revisions with a written one noted in drop_r
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            isb_dis_r <= CTRL_RST[`SLFC_ISB_DIS_BIT];
        end else if (wr_ctrl && PSTRB[3] && feat_r) begin
            isb_dis_r <= PWDATA[`SLFC_ISB_DIS_BIT];
        end
    end

    // Other bit positions hold no storage and read as zero
    always_comb begin
        ctrl_view = 32'h00000000;
        ctrl_view[`SLFC_SPLIT_DIS_BIT] = split_dis_r;
        ctrl_view[`SLFC_ISB_DIS_BIT]   = isb_dis_r;
    end

    // ****************************************************************
    // Dropped-write flag
    // ****************************************************************
    // A bit-30 write of one on older silicon is discarded but noted;
    // it only helps debug software that ignores the reserved bit
    assign drop_evt = wr_ctrl && PSTRB[3] && !feat_r &&
                      PWDATA[`SLFC_ISB_DIS_BIT];

    // Sticky, write one to clear; a new event wins over the clear
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            drop_r <= 1'b0;
        end else if (drop_evt) begin
            drop_r <= 1'b1;
        end else if (wr_stat && PSTRB[0] && PWDATA[`SLFC_ST_DROP_BIT]) begin
            drop_r <= 1'b0;
        end
    end

    // ****************************************************************
    // Lock sequencer
    // ****************************************************************
    slfc_lock_gen u_lock (
        .clk          (SYS_CLK),
        .rst_n        (RST_N),
        .seq_act      (CORE_LOCK_SEQ),
        .line_split   (CORE_LINE_SPLIT),
        .split_dis    (split_dis_r && feat_r),
        .lock_n       (lock_n),
        .bypass_pulse (byp_pulse),
        .seq_busy     (seq_busy)
    );

    assign BUS_LOCK_N = lock_n;

    // Count of unlocked split sequences, saturating; writing the
    // upper status half clears it, a same-cycle bypass still counts
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            byp_cnt_r <= 16'h0000;
        end else if (byp_pulse) begin
            if (byp_cnt_r != 16'hFFFF) begin
                byp_cnt_r <= byp_cnt_r + 16'h0001;
            end
        end else if (wr_stat && PSTRB[3] && PSTRB[2]) begin
            byp_cnt_r <= 16'h0000;
        end
    end

    // ****************************************************************
    // Prefetch enable
    // ****************************************************************
    // Registered so the fetch unit sees a clean level
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ISB_ENABLE <= 1'b1;
        end else begin
            ISB_ENABLE <= !isb_dis_r;
        end
    end

    // ****************************************************************
    // Status view
    // ****************************************************************
    always_comb begin
        stat_view = 32'h00000000;
        stat_view[`SLFC_ST_LOCK_BIT]  = !lock_n;
        stat_view[`SLFC_ST_SEQ_BIT]   = seq_busy;
        stat_view[`SLFC_ST_FEAT_BIT]  = feat_r;
        stat_view[`SLFC_ST_READY_BIT] = feat_ready_r;
        stat_view[`SLFC_ST_DROP_BIT]  = drop_r;
        stat_view[`SLFC_ST_CNT_MSB:`SLFC_ST_CNT_LSB] = byp_cnt_r;
    end

    // ****************************************************************
    // APB read path
    // ****************************************************************
    always_comb begin
        rd_mux = 32'h00000000;
        if (reg_sel(PADDR, `SLFC_CTRL_IDX)) begin
            rd_mux = ctrl_view;
        end else if (reg_sel(PADDR, `SLFC_STAT_IDX)) begin
            rd_mux = stat_view;
        end
    end

    // Data captured in the setup cycle so it is from a flop in the
    // access cycle; costs nothing since the slave never waits
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            PRDATA <= 32'h00000000;
        end else if (setup_ph) begin
            PRDATA <= PWRITE ? 32'h00000000 : rd_mux;
        end
    end

    // Unmapped addresses answer with an error, no state changes
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            PSLVERR <= 1'b0;
        end else if (setup_ph) begin
            PSLVERR <= !hit;
        end else if (!PSEL) begin
            PSLVERR <= 1'b0;
        end
    end

    // Zero wait states
    assign PREADY = 1'b1;

endmodule // slfc_top

// File: tb/slfc_top_sva.sv
// Purpose: Port-level checks for the lock and prefetch control block
// Assumes: Strap held steady across each reset, writes start late
// Notes:   Shadow bits track what software stored in the control word
`include "slfc_map.svh"

module slfc_top_sva #(
    parameter int AW = 12
) (
    input wire logic          SYS_CLK,
    input wire logic          RST_N,
    input wire logic          PSEL,
    input wire logic          PENABLE,
    input wire logic          PWRITE,
    input wire logic [AW-1:0] PADDR,
    input wire logic [31:0]   PWDATA,
    input wire logic [3:0]    PSTRB,
    input wire logic [31:0]   PRDATA,
    input wire logic          FEATURE_REV_PIN,
    input wire logic          CORE_LOCK_SEQ,
    input wire logic          CORE_LINE_SPLIT,
    input wire logic          BUS_LOCK_N,
    input wire logic          ISB_ENABLE
);
    localparam logic [AW-1:0] CTRL_A = AW'({`SLFC_CTRL_IDX, 2'h0});
    logic ctrl_hit;
    logic split_dis_r;
    logic isb_dis_r;

    // Control access in its access phase
    assign ctrl_hit = PSEL && PENABLE && (PADDR == CTRL_A);

    // Shadow of the two live bits; older silicon stores nothing
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            split_dis_r <= 1'b0;
            isb_dis_r   <= 1'b0;
        end else if (ctrl_hit && PWRITE && PSTRB[3] && FEATURE_REV_PIN) begin
            split_dis_r <= PWDATA[31];
            isb_dis_r   <= PWDATA[30];
        end
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);

    a_idle_release: assert property (!CORE_LOCK_SEQ |=> BUS_LOCK_N)
        else $error("lock held with no sequence");
    a_line_lock: assert property ($rose(CORE_LOCK_SEQ) && !CORE_LINE_SPLIT
        |=> !BUS_LOCK_N) else $error("single-line lock missing");
    a_lock_holds: assert property (CORE_LOCK_SEQ && !BUS_LOCK_N
        |=> !BUS_LOCK_N) else $error("lock dropped mid-sequence");
    a_lock_start_only: assert property ($fell(BUS_LOCK_N)
        |-> $past(CORE_LOCK_SEQ) && !$past(CORE_LOCK_SEQ, 2))
        else $error("lock asserted off sequence start");
    a_split_bypass: assert property ($rose(CORE_LOCK_SEQ) && CORE_LINE_SPLIT
        && split_dis_r |=> BUS_LOCK_N [*3])
        else $error("split lock not bypassed");
    a_split_locked: assert property ($rose(CORE_LOCK_SEQ) && CORE_LINE_SPLIT
        && !split_dis_r |=> !BUS_LOCK_N)
        else $error("split lock not asserted");
    a_isb_track: assert property (ctrl_hit && PWRITE && PSTRB[3]
        |-> ##2 ISB_ENABLE == !$past(isb_dis_r))
        else $error("streaming enable mismatch");
    a_ctrl_readback: assert property (ctrl_hit && !PWRITE
        |-> PRDATA == {split_dis_r, isb_dis_r, 30'h0})
        else $error("control readback mismatch");
endmodule // slfc_top_sva

bind slfc_top slfc_top_sva #(.AW(AW)) u_sva (.SYS_CLK(SYS_CLK),
    .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
    .FEATURE_REV_PIN(FEATURE_REV_PIN), .CORE_LOCK_SEQ(CORE_LOCK_SEQ),
    .CORE_LINE_SPLIT(CORE_LINE_SPLIT), .BUS_LOCK_N(BUS_LOCK_N),
    .ISB_ENABLE(ISB_ENABLE));

// File: tb/slfc_bus_agent.sv
// Purpose: Another agent on the shared system bus
// Assumes: Same clock as the block
// Notes:   Wins the bus only while no lock is held
module slfc_bus_agent (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic lock_n,
    input  wire logic want,
    output logic      owned
);
    timeunit 1ns;
    timeprecision 1ps;

    // Arbitration: a held lock keeps this agent off the bus
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            owned <= 1'b0;
        end else begin
            owned <= want && lock_n;
        end
    end
endmodule // slfc_bus_agent

// File: tb/testbench.sv
// Purpose: Self-checking bench for the lock and prefetch control block
// Assumes: Zero wait-state slave, strap fixed per reset
// Notes:   Random split and control values from a fixed seed
`include "slfc_map.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] CTRL_A = 12'({`SLFC_CTRL_IDX, 2'h0});
    localparam logic [11:0] STAT_A = 12'({`SLFC_STAT_IDX, 2'h0});
    logic [3:0]  pstrb, strb;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        feat, seq, split, lock_n, isb_en, owned;
    int          errors, num_checks;

    slfc_top u_slfc_top (.SYS_CLK(clk), .RST_N(rst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .FEATURE_REV_PIN(feat), .CORE_LOCK_SEQ(seq), .CORE_LINE_SPLIT(split),
        .BUS_LOCK_N(lock_n), .ISB_ENABLE(isb_en));
    slfc_bus_agent u_slfc_bus_agent (.clk(clk), .rst_n(rst_n),
        .lock_n(lock_n), .want(1'b1), .owned(owned));

    // Clock, 10 ns period
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic results();
        $display("errors %0d checks %0d", errors, num_checks);
        if (errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One APB transfer; waits on pready so slow answers also work
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= strb;
        @(posedge clk);
        penable <= 1'b1;
        // Only the watchdog ends a wait that never sees ready
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Locked sequence of len+1 cycles, lock checked on the last len; lk says whether lock must show
    task automatic lockseq(input logic sp, input int len, input logic lk);
        @(posedge clk);
        seq <= 1'b1;
        split <= sp;
        @(posedge clk);
        repeat (len) begin
            @(posedge clk);
            chk(lock_n, !lk);
        end
        chk(owned, !lk);
        seq <= 1'b0;
        repeat (2) @(posedge clk);
        chk(lock_n, 1'b1);
    endtask

    // Reset held 20 cycles, then room for the strap capture
    task automatic rst(input logic f);
        feat <= f;
        rst_n <= 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask

    // Watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        results();
    end

    initial begin
        logic [31:0] d, q;
        logic        e, sp;
        int          nbyp;
        {rst_n, psel, penable, pwrite, seq, split, feat} = '0;
        pstrb = 4'hF;
        strb = 4'hF;
        nbyp = 0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        errors = 0;
        num_checks = 0;
        d = $urandom(32'h9F4A099E);
        rst(1'b1);
        apb(1'b0, CTRL_A, 32'h00000000, q, e);
        chk(q, 32'h00000000);
        chk(isb_en, 1'b1);
        apb(1'b0, 12'h100, 32'h00000000, q, e);
        chk(e, 1'b1);
        // Corner values first, then random words
        for (int i = 0; i < 12; i++) begin
            d = (i < 4) ? {i[1:0], 30'h3FFFFFFF} : $urandom;
            apb(1'b1, CTRL_A, d, q, e);
            apb(1'b0, CTRL_A, 32'h00000000, q, e);
            chk(q, d & 32'hC0000000);
            repeat (2) @(posedge clk);
            chk(isb_en, !d[30]);
            sp = $urandom_range(0, 1);
            // Split sequences expected to run without the lock
            nbyp = nbyp + int'(sp & d[31]) + int'(d[31]);
            lockseq(sp, 2 + $urandom_range(0, 3), !(sp && d[31]));
            lockseq(1'b0, 2, 1'b1);
            lockseq(1'b1, 3, !d[31]);
        end
        // Write without the top byte strobe must leave both bits alone
        strb = 4'h7;
        apb(1'b1, CTRL_A, ~d, q, e);
        strb = 4'hF;
        apb(1'b0, CTRL_A, 32'h00000000, q, e);
        chk(q, d & 32'hC0000000);
        repeat (2) @(posedge clk);
        chk(isb_en, !d[30]);
        // Status: feature and ready bits plus unlocked split count
        apb(1'b0, STAT_A, 32'h00000000, q, e);
        chk(q, {nbyp[15:0], 16'h000C});
        apb(1'b1, STAT_A, 32'h00000000, q, e);
        apb(1'b0, STAT_A, 32'h00000000, q, e);
        chk(q, 32'h0000000C);
        // Older silicon: software normally leaves these bits alone
        rst(1'b0);
        apb(1'b1, CTRL_A, 32'hC0000000, q, e);
        apb(1'b0, CTRL_A, 32'h00000000, q, e);
        chk(q, 32'h00000000);
        repeat (2) @(posedge clk);
        chk(isb_en, 1'b1);
        // Dropped bit-30 write is flagged, then cleared by write one
        apb(1'b0, STAT_A, 32'h00000000, q, e);
        chk(q, 32'h00000018);
        apb(1'b1, STAT_A, 32'h00000010, q, e);
        apb(1'b0, STAT_A, 32'h00000000, q, e);
        chk(q, 32'h00000008);
        lockseq(1'b1, 3, 1'b1);
        results();
    end
endmodule // testbench
